// ### logic/pol_latch.sv
// pol_latch: 32-point active-low output latch on a wishbone backplane
// assumes the master is classic single-cycle wishbone on clk_sys_i;
// switches, jumpers, fault and user power are asynchronous pins
//
// The implementer's own choices: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module pol_latch (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [4:0] addr_switch_i,
  input wire logic fault_response_jumper_i,
  input wire logic polarity_jumper_i,
  input wire logic sys_fault_i,
  input wire logic user_power_ok_i,
  output logic [31:0] out_n_o,
  output logic [31:0] out_led_o,
  output logic hold_led_o,
  output logic invert_led_o
);
  logic [pol_pkg::SYNC_W-1:0] sync_a;
  logic [pol_pkg::SYNC_W-1:0] sync_b;
  logic [4:0] sw;
  logic hold_mode;
  logic invert_mode;
  logic fault;
  logic power_ok;
  logic [31:0] latch;
  logic [31:0] next_latch;
  logic [31:0] on_bits;
  logic req;
  logic hit_slice;
  logic hit_status;
  logic hit_readback;
  logic in_table;
  logic wr_slice;
  logic [31:0] next_rdata;
  logic [31:0] lane_mask;

  // two flip-flops on every pin input; only stage b is read by logic
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      sync_a <= '0;
      sync_b <= '0;
    end
    else
    begin
      sync_a <= {user_power_ok_i, sys_fault_i, polarity_jumper_i, fault_response_jumper_i, addr_switch_i};
      sync_b <= sync_a;
    end
  end

  // unpack the synced pins; the switches are static, so a per-bit
  // synchroniser without a gray code is good enough for them
  assign sw = sync_b[4:0];
  assign hold_mode = sync_b[5];
  assign invert_mode = sync_b[6];
  assign fault = sync_b[7];
  assign power_ok = sync_b[8];

  // address decode: the table word picked by the switches belongs to us
  assign req = wb_cyc_i && wb_stb_i;
  assign in_table = (wb_adr_i <= pol_pkg::TABLE_LAST);
  assign hit_slice = in_table && (wb_adr_i[6:2] == sw) && (wb_adr_i[1:0] == 2'b00);
  assign hit_status = (wb_adr_i == pol_pkg::STATUS_OFS);
  assign hit_readback = (wb_adr_i == pol_pkg::READBACK_OFS);
  // writes take effect on the ack edge; data in a fault is not valid
  assign wr_slice = req && wb_ack_o && wb_we_i && hit_slice && !fault;

  // ack one cycle after the request is seen, dropped the cycle after;
  // every address is answered so a missing slot never hangs the bus
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= req && !wb_ack_o;
  end

  // read mux: other table words and unmapped offsets read as zero
  always_comb
  begin
    next_rdata = '0;
    if (hit_slice)
      next_rdata = latch;
    else if (hit_status)
    begin
      next_rdata[pol_pkg::ST_HOLD] = hold_mode;
      next_rdata[pol_pkg::ST_INVERT] = invert_mode;
      next_rdata[pol_pkg::ST_FAULT] = fault;
      next_rdata[pol_pkg::ST_POWER] = power_ok;
      next_rdata[pol_pkg::ST_SW_LSB +: pol_pkg::SW_W] = sw;
    end
    else if (hit_readback)
      next_rdata = ~out_n_o;
  end

  // read data is captured once per request and stands through the ack
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
      wb_dat_o <= '0;
    else if (req && !wb_ack_o)
      wb_dat_o <= next_rdata;
  end

  // per group byte-lane update; one full-word write refreshes all four
  genvar g;
  generate
    for (g = 0; g < pol_pkg::GROUPS; g++)
    begin : grp
      always_comb
      begin
        next_latch[g*pol_pkg::GROUP_W +: pol_pkg::GROUP_W] = latch[g*pol_pkg::GROUP_W +: pol_pkg::GROUP_W];
        if (wr_slice && wb_sel_i[g])
          next_latch[g*pol_pkg::GROUP_W +: pol_pkg::GROUP_W] = wb_dat_i[g*pol_pkg::GROUP_W +: pol_pkg::GROUP_W];
      end
      // byte-lane mask, read only by the lane checks below
      assign lane_mask[g*pol_pkg::GROUP_W +: pol_pkg::GROUP_W] = {pol_pkg::GROUP_W{wb_sel_i[g]}};
    end
  endgenerate

  // latched slice: cleared by missing user power, or by a fault when the
  // jumper selects disable; in hold mode a fault freezes the last state
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
      latch <= pol_pkg::LATCH_RST;
    else if (!power_ok)
      latch <= pol_pkg::LATCH_RST;
    else if (fault && hold_mode == pol_pkg::JP_DISABLE)
      latch <= pol_pkg::LATCH_RST;
    else
      latch <= next_latch;
  end

  // polarity: on-state is the table bit, complemented in inverting mode
  assign on_bits = (invert_mode == pol_pkg::JP_INVERT) ? ~latch : latch;

  // outputs from flops; kept off until power is up and data have been
  // latched, so the inverting mode cannot turn points on at power-up
  logic primed;
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
      primed <= 1'b0;
    else if (!power_ok || (fault && hold_mode == pol_pkg::JP_DISABLE))
      primed <= 1'b0;
    else if (wr_slice)
      primed <= 1'b1;
  end

  // output and indicator registers; all off while not primed
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      out_n_o <= pol_pkg::OUT_OFF_N;
      out_led_o <= '0;
    end
    else if (!primed)
    begin
      out_n_o <= pol_pkg::OUT_OFF_N;
      out_led_o <= '0;
    end
    else
    begin
      out_n_o <= ~on_bits; // output k+1 is bit k, low when on
      out_led_o <= on_bits;
    end
  end

  // mode indicators follow the jumpers
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      hold_led_o <= 1'b0;
      invert_led_o <= 1'b0;
    end
    else
    begin
      hold_led_o <= (hold_mode == pol_pkg::JP_HOLD);
      invert_led_o <= (invert_mode == pol_pkg::JP_INVERT);
    end
  end

  // checks on the latch, its bus and its outputs
  sequence s_write_ok;
    wr_slice && (wb_sel_i == 4'hf) && !(hold_mode == pol_pkg::JP_DISABLE && fault) && power_ok;
  endsequence
  sequence s_drive;
    primed ##1 (out_led_o == $past(on_bits));
  endsequence
  sequence s_bus_req;
    req && !wb_ack_o;
  endsequence

  // no user power: points off two edges after the synced level
  chk_power_off: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    !power_ok |=> ##1 (out_n_o == pol_pkg::OUT_OFF_N))
    else $error("outputs not off without user power");

  // fault with the disable setting: every point goes off
  chk_fault_disable: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (fault && hold_mode == pol_pkg::JP_DISABLE) |=> ##1 (out_n_o == pol_pkg::OUT_OFF_N))
    else $error("fault did not force outputs off");

  // stored data is dropped too, so old states never come back by themselves
  chk_power_clear: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    !power_ok |=> (latch == pol_pkg::LATCH_RST) && !primed)
    else $error("latch kept data without user power");

  // disable setting: a fault wipes the slice and waits for new data
  chk_fault_clear: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (fault && hold_mode == pol_pkg::JP_DISABLE) |=> (latch == pol_pkg::LATCH_RST) && !primed)
    else $error("fault in disable setting kept data");

  // until a valid write arrives every point stays off, whatever the polarity
  chk_unprimed_off: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    !primed |=> (out_n_o == pol_pkg::OUT_OFF_N) && (out_led_o == 32'h0000_0000))
    else $error("outputs on before any valid write");

  // hold setting: a fault freezes the slice
  chk_fault_hold: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (fault && hold_mode == pol_pkg::JP_HOLD && power_ok && $past(power_ok)) |=> $stable(latch))
    else $error("latch changed during fault in hold mode");

  // normal mode: a one bit pulls its pin low two edges after the write
  chk_normal_map: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (s_write_ok and (invert_mode == pol_pkg::JP_NORMAL)) ##1 (power_ok && !fault && !wr_slice
      && invert_mode == pol_pkg::JP_NORMAL) |=> (out_n_o == ~$past(wb_dat_i, 2)))
    else $error("normal mode mapping wrong");

  // inverting mode: a zero bit pulls its pin low
  chk_invert_map: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (s_write_ok and (invert_mode == pol_pkg::JP_INVERT)) ##1 (power_ok && !fault && !wr_slice
      && invert_mode == pol_pkg::JP_INVERT) |=> (out_n_o == $past(wb_dat_i, 2)))
    else $error("inverting mode mapping wrong");

  // each indicator lights exactly when its point is driven low
  chk_led_mirror: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    1'b1 |-> (out_led_o == ~out_n_o))
    else $error("point indicators disagree with outputs");

  // writes to other table words leave the slice alone
  chk_slice_decode: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (req && wb_ack_o && wb_we_i && wb_adr_i[6:2] != sw && power_ok && !fault) |=> $stable(latch))
    else $error("write outside the selected slice changed the latch");

  // table words that belong to other modules read as zero
  chk_other_word: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    s_bus_req ##0 (in_table && !hit_slice) |=> (wb_dat_o == 32'h0000_0000))
    else $error("foreign table word did not read as zero");

  // groups whose lane is not selected keep their points
  chk_group_lane: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (wr_slice && power_ok) |=> (((latch ^ $past(latch)) & ~$past(lane_mask)) == 32'h0000_0000))
    else $error("untouched groups changed");

  // selected groups take the written bits, bit k to point k+1
  chk_lane_write: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (wr_slice && power_ok) |=> (((latch ^ $past(wb_dat_i)) & $past(lane_mask)) == 32'h0000_0000))
    else $error("selected groups did not take the written data");

  // a full word write refreshes all 32 points next edge and reaches the pins one edge after that
  chk_full_refresh: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    s_write_ok |=> (latch == $past(wb_dat_i)) ##0 s_drive)
    else $error("full word write did not refresh all points");

  // mode indicators show the synced jumper levels one edge later
  chk_mode_leds: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    1'b1 |=> (hold_led_o == ($past(hold_mode) == pol_pkg::JP_HOLD))
      && (invert_led_o == ($past(invert_mode) == pol_pkg::JP_INVERT)))
    else $error("mode indicators wrong");

  // status word reports jumpers and switches as the logic sees them
  chk_status_word: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    s_bus_req ##0 hit_status |=> (wb_dat_o[pol_pkg::ST_HOLD] == $past(hold_mode))
      && (wb_dat_o[pol_pkg::ST_INVERT] == $past(invert_mode))
      && (wb_dat_o[pol_pkg::ST_SW_LSB +: pol_pkg::SW_W] == $past(sw)))
    else $error("status word wrong");

  // read-back shows the on state of every point
  chk_readback_word: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    s_bus_req ##0 hit_readback |=> (wb_dat_o == ~$past(out_n_o)))
    else $error("read-back word wrong");

  // ack is a single pulse one cycle after the request
  chk_ack_pulse: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    s_bus_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single cycle pulse");

  // no request, no ack: a stray ack would land a phantom write
  chk_ack_idle: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    !req |=> !wb_ack_o)
    else $error("ack without a request");

  // read data stands unchanged after the ack cycle
  chk_data_hold: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    wb_ack_o |=> $stable(wb_dat_o))
    else $error("read data changed after ack");
endmodule // pol_latch
`default_nettype wire

// ### logic/pol_pkg.sv
// pol_pkg: constants shared by the 32-point output latch
// assumes a 32-bit classic wishbone backplane with byte addresses
`default_nettype none
package pol_pkg;
  localparam int unsigned POINTS = 32;
  localparam int unsigned GROUPS = 4;
  localparam int unsigned GROUP_W = 8;
  localparam int unsigned SW_W = 5;
  localparam int unsigned ADR_W = 8;
  // output status table: 32 words of 32 bits at byte offset 4*n
  localparam logic [7:0] TABLE_BASE = 8'h00;
  localparam logic [7:0] TABLE_LAST = 8'h7c;
  // module status and read-back words, placed above the table
  localparam logic [7:0] STATUS_OFS = 8'h80;
  localparam logic [7:0] READBACK_OFS = 8'h84;
  // status word field positions
  localparam int unsigned ST_HOLD = 0;
  localparam int unsigned ST_INVERT = 1;
  localparam int unsigned ST_FAULT = 2;
  localparam int unsigned ST_POWER = 3;
  localparam int unsigned ST_SW_LSB = 8;
  // value after reset and after user power comes up: every point off
  localparam logic [31:0] LATCH_RST = 32'h0000_0000;
  localparam logic [31:0] OUT_OFF_N = 32'hffff_ffff;
  // jumper levels: 1-2 position reads low, 2-3 position reads high
  localparam logic JP_DISABLE = 1'b0;
  localparam logic JP_HOLD = 1'b1;
  localparam logic JP_NORMAL = 1'b0;
  localparam logic JP_INVERT = 1'b1;
  localparam int unsigned SYNC_W = 9;
endpackage
`default_nettype wire

// ### sim/pol_cpu_model.sv
// pol_cpu_model: controller side of the backplane, a classic wishbone master
// assumes one request at a time; the bench watchdog ends a wait for ack
`timescale 1ns/1ps
`default_nettype none
module pol_cpu_model (
  input wire logic clk_i,
  input wire logic ack_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [7:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o
);
  // bus idle at time zero
  initial
  begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'h0;
    dat_o = 32'h0000_0000;
  end

  // one single cycle; request held until ack seen, then a gap of one cycle at least
  task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    @(posedge clk_i);
    {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <= {2'b11, w, a, s, d};
    do @(posedge clk_i); while (ack_i !== 1'b1);
    {cyc_o, stb_o, we_o} <= 3'b000;
    dat_o <= ~d; // stale data is not left on the lines
  endtask
endmodule // pol_cpu_model
`default_nettype wire

// ### sim/test_parallel_output_latch_32.sv
// test_parallel_output_latch_32: self-checking bench for pol_latch
// assumes pol_pkg compiled first; reads are checked by a monitor from a queue
`timescale 1ns/1ps
`default_nettype none
module test_parallel_output_latch_32;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic [4:0] sw = 5'h00;
  logic fj = 1'b0;
  logic pj = 1'b0;
  logic flt = 1'b0;
  logic pwr = 1'b1;
  logic [31:0] d;
  logic [31:0] d2;
  logic [7:0] a;
  integer seed = 32'h45c1462f;
  int mismatches = 0;
  int n_checks = 0;
  logic [31:0] exp_q[$];
  wire logic cyc, stb, we, ack, hled, iled;
  wire logic [7:0] adr;
  wire logic [3:0] sel;
  wire logic [31:0] dw, dr, outn, led;

  always #4 clk_sys_i = ~clk_sys_i;

  pol_cpu_model cpu (.clk_i(clk_sys_i), .ack_i(ack), .cyc_o(cyc), .stb_o(stb), .we_o(we),
    .adr_o(adr), .sel_o(sel), .dat_o(dw));

  pol_latch u_pol_latch (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack),
    .addr_switch_i(sw), .fault_response_jumper_i(fj), .polarity_jumper_i(pj), .sys_fault_i(flt),
    .user_power_ok_i(pwr), .out_n_o(outn), .out_led_o(led), .hold_led_o(hled), .invert_led_o(iled));

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  // pins pass two sync flops and the output register, so five edges is ample
  task automatic settle;
    repeat (5) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic pins(input logic [31:0] on);
    chk("out_n", ~on, outn);
    chk("out_led", on, led);
  endtask

  task automatic rd(input logic [7:0] ad, input logic [31:0] e);
    exp_q.push_back(e);
    cpu.xfer(1'b0, ad, 4'hf, 32'h0000_0000);
  endtask

  // read data is taken only at the ack edge of a read
  always @(posedge clk_sys_i)
  begin
    if (ack === 1'b1 && we === 1'b0)
      chk("read", exp_q.pop_front(), dr);
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // watchdog: the whole sequence needs well under a thousand cycles
  initial
  begin
    #40000;
    mismatches++;
    print_verdict();
  end

  initial
  begin
    repeat (6) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    sw <= 5'($random(seed)) | 5'h02;
    settle();
    pins(32'h0);
    a = {sw, 2'b00};
    rd(pol_pkg::STATUS_OFS, {19'h0, sw, 8'h08});
    d = $random(seed);
    cpu.xfer(1'b1, a, 4'hf, d);
    settle();
    pins(d);
    chk("loopback", d, ~outn);
    cpu.xfer(1'b1, {sw ^ 5'h01, 2'b00}, 4'hf, ~d);
    settle();
    pins(d);
    rd({sw ^ 5'h01, 2'b00}, 32'h0);
    d2 = $random(seed);
    cpu.xfer(1'b1, a, 4'h4, d2);
    d[23:16] = d2[23:16];
    settle();
    pins(d);
    @(posedge clk_sys_i) pj <= 1'b1;
    settle();
    pins(~d);
    chk("invert_led", 32'h1, {31'h0, iled});
    rd(pol_pkg::READBACK_OFS, ~d);
    d = $random(seed);
    cpu.xfer(1'b1, a, 4'hf, d);
    settle();
    pins(~d);
    chk("loopback", d, outn);
    @(posedge clk_sys_i) {pj, fj, flt} <= 3'b011;
    settle();
    chk("hold_led", 32'h1, {31'h0, hled});
    cpu.xfer(1'b1, a, 4'hf, ~d);
    settle();
    pins(d);
    @(posedge clk_sys_i) flt <= 1'b0;
    settle();
    cpu.xfer(1'b1, a, 4'hf, ~d);
    d = ~d;
    settle();
    pins(d);
    @(posedge clk_sys_i) {fj, flt} <= 2'b01;
    settle();
    pins(32'h0);
    @(posedge clk_sys_i) flt <= 1'b0;
    settle();
    pins(32'h0);
    cpu.xfer(1'b1, a, 4'hf, d);
    @(posedge clk_sys_i) pwr <= 1'b0;
    settle();
    pins(32'h0);
    @(posedge clk_sys_i) pwr <= 1'b1;
    settle();
    pins(32'h0);
    print_verdict();
  end
endmodule // test_parallel_output_latch_32
`default_nettype wire
